// ==== common/sarx_pkg.sv ====
/*
 Package for the stack and rotate execution slice: opcodes, instruction
 lengths, cycle counts, flag bit positions and the request carrier.
 Assumes one 200 MHz core clock and a synchronous active-low reset.
*/
package sarx_pkg;
   // Opcodes of the slice
   localparam logic [7:0] OP_PUSH_R = 8'h70;
   localparam logic [7:0] OP_PUSH_IR = 8'h71;
   localparam logic [7:0] OP_USER_STACK_STORE_DOWN = 8'h82;
   localparam logic [7:0] OP_USER_STACK_STORE_UP = 8'h83;
   localparam logic [7:0] OP_CLEAR_CARRY = 8'hcf;
   localparam logic [7:0] OP_SUBROUTINE_RETURN = 8'haf;
   localparam logic [7:0] OP_ROTATE_LEFT_R = 8'h90;
   localparam logic [7:0] OP_ROTATE_LEFT_IR = 8'h91;
   localparam logic [7:0] OP_RLC_R = 8'h10;
   localparam logic [7:0] OP_RLC_IR = 8'h11;
   localparam logic [7:0] OP_ROTATE_RIGHT_R = 8'he0;
   localparam logic [7:0] OP_ROTATE_RIGHT_IR = 8'he1;
   localparam logic [7:0] OP_RRC_R = 8'hc0;
   localparam logic [7:0] OP_RRC_IR = 8'hc1;

   // Lengths in bytes
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // Cycle counts
   localparam logic [3:0] CYC_FOUR = 4'h4;
   localparam logic [3:0] CYC_EIGHT = 4'h8;
   localparam logic [3:0] CYC_TEN = 4'ha;

   // Flag bit positions: carry, zero, sign, overflow, decimal, half
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;

   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] SP_STEP_RET = 16'h0002;

   // One decoded instruction handed to the block
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] dst;  // Register or indirect register byte
      logic [7:0] src;  // Source register byte
   } sarx_instr_type;

   // Register-file access port
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sarx_rf_type;

   // Data-memory (stack) access port
   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sarx_mem_type;

   typedef enum {
      ST_IDLE, ST_RD1, ST_RD2, ST_RD3, ST_EXEC, ST_MEM2, ST_WAIT
   } sarx_state_type;
endpackage : sarx_pkg

// ==== design/sarx_exec.sv ====
/*
 Execution unit for push, user-stack stores, clear carry, return and the
 four rotates. Holds the stack pointer, program counter and flags.
 Each instruction runs for its full cycle count, counted from the edge
 that takes it, and ends with a one-cycle done pulse.
 Assumes a register file and a stack memory on the same clock, each
 returning read data one cycle after the address is presented.
 Assumes the register file applies a write on the edge after the write
 pulse, so a write issued together with done lands one edge later.
 Assumes the caller holds off a new start until the edge after done.
*/
`timescale 1ns/1ps
module sarx_exec (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire sarx_pkg::sarx_instr_type i_instr,
   input wire logic [7:0] i_rf_rdata,
   input wire logic [7:0] i_mem_rdata,
   output sarx_pkg::sarx_rf_type o_rf,
   output sarx_pkg::sarx_mem_type o_mem,
   output logic [15:0] o_stack_pointer,
   output logic [15:0] o_program_counter,
   output logic [7:0] o_flags,
   output logic [1:0] o_length,
   output logic o_busy,
   output logic o_done,
   output logic o_illegal
);
   import sarx_pkg::*;

   // Sequencer state and the instruction held for its run; a user store rewrites its opcode and src
   sarx_state_type state_q;
   sarx_instr_type ins_q;
   // Registered ports; nothing reaches an output without a flop
   sarx_rf_type rf_q;
   sarx_mem_type mem_q;
   // Architectural state and operand scratch
   logic [15:0] sp_q, pc_q;
   logic [7:0] flags_q, ptr_q, val_q;
   logic [1:0] len_q;
   logic [3:0] cnt_q;
   logic busy_q, done_q, ill_q;

   // Opcode decode
   // Decode works on the held instruction, not the input, so the
   // input may change freely once the start is taken
   wire [7:0] op = ins_q.opcode;
   wire is_push = (op == OP_PUSH_R) || (op == OP_PUSH_IR);
   wire is_ud = (op == OP_USER_STACK_STORE_DOWN);
   wire is_ui = (op == OP_USER_STACK_STORE_UP);
   wire is_rl = (op == OP_ROTATE_LEFT_R) || (op == OP_ROTATE_LEFT_IR);
   wire is_rlc = (op == OP_RLC_R) || (op == OP_RLC_IR);
   wire is_rr = (op == OP_ROTATE_RIGHT_R) || (op == OP_ROTATE_RIGHT_IR);
   wire is_rrc = (op == OP_RRC_R) || (op == OP_RRC_IR);
   wire is_rot = is_rl || is_rlc || is_rr || is_rrc;
   wire is_ind = (op == OP_PUSH_IR) || (op == OP_ROTATE_LEFT_IR)
      || (op == OP_RLC_IR) || (op == OP_ROTATE_RIGHT_IR)
      || (op == OP_RRC_IR);

   // Incoming opcode check; anything outside the slice is flagged and
   // dropped so a stray start never disturbs the machine state
   wire [7:0] sd = i_instr.opcode;
   wire known = (sd == OP_PUSH_R) || (sd == OP_PUSH_IR)
      || (sd == OP_USER_STACK_STORE_DOWN) || (sd == OP_USER_STACK_STORE_UP)
      || (sd == OP_CLEAR_CARRY) || (sd == OP_SUBROUTINE_RETURN)
      || (sd == OP_ROTATE_LEFT_R) || (sd == OP_ROTATE_LEFT_IR)
      || (sd == OP_RLC_R) || (sd == OP_RLC_IR)
      || (sd == OP_ROTATE_RIGHT_R) || (sd == OP_ROTATE_RIGHT_IR)
      || (sd == OP_RRC_R) || (sd == OP_RRC_IR);

   // Byte length of the incoming instruction
   // Only the one- and three-byte cases need naming
   // push length
   wire [1:0] len_in =
      (sd == OP_CLEAR_CARRY || sd == OP_SUBROUTINE_RETURN) ? LEN_ONE :
      (sd == OP_USER_STACK_STORE_DOWN || sd == OP_USER_STACK_STORE_UP)
         ? LEN_THREE : LEN_TWO;

   // Total cycles per instruction
   // Rotates and clear carry share the four-cycle default
   wire [3:0] cyc_in =
      (sd == OP_SUBROUTINE_RETURN) ? CYC_TEN :
      (sd == OP_PUSH_R || sd == OP_PUSH_IR
       || sd == OP_USER_STACK_STORE_DOWN
       || sd == OP_USER_STACK_STORE_UP) ? CYC_EIGHT : CYC_FOUR;

   // Rotate datapath on the fetched operand
   // All four results are built in parallel and one is selected; the
   // carry always takes the bit that falls off the end
   // rotate left
   wire [7:0] rl_res = {val_q[6:0], val_q[7]};
   wire [7:0] rlc_res = {val_q[6:0], flags_q[FLAG_C]};
   wire [7:0] rr_res = {val_q[0], val_q[7:1]};
   wire [7:0] rrc_res = {flags_q[FLAG_C], val_q[7:1]};
   wire [7:0] rot_res = is_rl ? rl_res : is_rlc ? rlc_res :
      is_rr ? rr_res : rrc_res;
   wire rot_c = (is_rl || is_rlc) ? val_q[7] : val_q[0];
   logic [7:0] rot_flags;
   always_comb begin
      rot_flags = flags_q;
      rot_flags[FLAG_C] = rot_c;
      rot_flags[FLAG_Z] = (rot_res == 8'h00);
      rot_flags[FLAG_S] = rot_res[7];
      rot_flags[FLAG_V] = rot_res[7] ^ val_q[7];
   end

   // Pointer arithmetic; the wrap is left to the adder width
   // decrement with natural wrap
   wire [15:0] sp_dec = sp_q - 16'h0001;
   wire [7:0] uptr = is_ud ? (ptr_q - 8'h01) : (ptr_q + 8'h01);
   wire [15:0] sp_ret = sp_q + SP_STEP_RET;
   wire [15:0] sp_p1 = sp_q + 16'h0001;

   // Sequencer: RD1 reads the first operand; RD2 follows an indirection
   // RD3 takes the operand value of indirect forms and user stores (RD2 for direct ones), EXEC writes back, WAIT pads the count.
   // Return reads its two stack bytes from RD1 and RD2 and lands them
   // in RD2 and MEM2; a user store writes its pointer in EXEC and the
   // value in the first WAIT cycle.
   // The counter is loaded with the full count and runs down while
   // busy; the end is taken wherever the state machine stands then.
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         // Clear everything, ports included, so outputs read zero
         state_q <= ST_IDLE;
         ins_q <= '0;
         rf_q <= '0;
         mem_q <= '0;
         sp_q <= SP_RESET;
         pc_q <= PC_RESET;
         flags_q <= FLAGS_RESET;
         ptr_q <= 8'h00;
         val_q <= 8'h00;
         len_q <= 2'h0;
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         ill_q <= 1'b0;
      end else begin
         // Pulses default low and are raised for one edge only
         rf_q.we <= 1'b0;
         mem_q.we <= 1'b0;
         mem_q.re <= 1'b0;
         done_q <= 1'b0;
         ill_q <= 1'b0;
         // Count down the run while busy
         if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
         case (state_q)
            ST_IDLE: begin
               // A start while busy never reaches this state
               if (i_start && known) begin
                  ins_q <= i_instr;
                  len_q <= len_in;
                  cnt_q <= cyc_in;
                  busy_q <= 1'b1;
                  state_q <= ST_RD1;
               end else if (i_start) begin
                  ill_q <= 1'b1;
               end
            end
            ST_RD1: begin
               if (op == OP_CLEAR_CARRY) begin
                  flags_q[FLAG_C] <= 1'b0;
                  state_q <= ST_WAIT;
               end else if (op == OP_SUBROUTINE_RETURN) begin
                  mem_q.re <= 1'b1;
                  mem_q.addr <= sp_q;
                  state_q <= ST_RD2;
               end else begin
                  // Dst byte for user stores, else the operand register
                  rf_q.addr <= (is_ud || is_ui) ? ins_q.dst :
                     is_push ? ins_q.src : ins_q.dst;
                  state_q <= ST_RD2;
               end
            end
            ST_RD2: begin
               if (op == OP_SUBROUTINE_RETURN) begin
                  // high byte stands now; read the low byte next
                  pc_q[15:8] <= i_mem_rdata;
                  mem_q.re <= 1'b1;
                  mem_q.addr <= sp_p1;
                  state_q <= ST_RD3;
               end else if (is_ind) begin
                  rf_q.addr <= i_rf_rdata;
                  state_q <= ST_RD3;
               end else if (is_ud || is_ui) begin
                  ptr_q <= i_rf_rdata;
                  rf_q.addr <= ins_q.src;
                  state_q <= ST_RD3;
               end else begin
                  val_q <= i_rf_rdata;
                  state_q <= ST_EXEC;
               end
            end
            ST_RD3: begin
               if (op == OP_SUBROUTINE_RETURN) begin
                  // Low byte is taken in MEM2, its address held still
                  state_q <= ST_MEM2;
               end else begin
                  // Operand value for rotate, push or user store
                  val_q <= i_rf_rdata;
                  state_q <= ST_EXEC;
               end
            end
            ST_MEM2: begin
               // low byte, pointer plus two
               // Pointer moves only after both bytes are in
               pc_q[7:0] <= i_mem_rdata;
               sp_q <= sp_ret;
               state_q <= ST_WAIT;
            end
            ST_EXEC: begin
               if (is_rot) begin
                  rf_q.we <= 1'b1;
                  rf_q.wdata <= rot_res;
                  flags_q <= rot_flags;
               end else if (is_push) begin
                  sp_q <= sp_dec;
                  mem_q.we <= 1'b1;
                  mem_q.addr <= sp_dec;
                  mem_q.wdata <= val_q;
               end else begin
                  rf_q.we <= 1'b1;
                  rf_q.addr <= ins_q.dst;
                  rf_q.wdata <= uptr;
                  ptr_q <= uptr;
               end
               state_q <= (is_ud || is_ui) ? ST_MEM2 : ST_WAIT;
               if (is_ud || is_ui) begin
                  state_q <= ST_WAIT;
                  ins_q.opcode <= 8'h00;
                  ins_q.src <= uptr;
               end
            end
            ST_WAIT: begin
               // Second write of a user store: value into pointed register
               if (ins_q.opcode == 8'h00) begin
                  rf_q.we <= 1'b1;
                  rf_q.addr <= ins_q.src;
                  rf_q.wdata <= val_q;
                  ins_q.opcode <= OP_CLEAR_CARRY;
               end
            end
            default: begin
               // Unreachable; recover to idle
               state_q <= ST_IDLE;
            end
         endcase
         // End of run: the counter alone decides, so an indirect rotate
         // may end on the very edge of its write-back and still keep
         // its four-cycle budget
         if (busy_q && (cnt_q == 4'h1)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            // Return has already loaded the counter from the stack
            if (op != OP_SUBROUTINE_RETURN) begin
               pc_q <= pc_q + {14'h0000, len_q};
            end
            state_q <= ST_IDLE;
         end
      end
   end

   // Outputs straight from flops
   // The port structs are whole flop groups, so no decode glitch leaves
   assign o_rf = rf_q;
   assign o_mem = mem_q;
   assign o_stack_pointer = sp_q;
   assign o_program_counter = pc_q;
   assign o_flags = flags_q;
   assign o_length = len_q;
   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_illegal = ill_q;
endmodule : sarx_exec

// ==== verif/sarx_exec_props.sv ====
/*
 Checker for sarx_exec: end timing and flag relations at the ports.
 Assumes it is bound into sarx_exec and sees only that top's ports.
*/
`timescale 1ns/1ps
module sarx_exec_props import sarx_pkg::*; (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire sarx_pkg::sarx_instr_type i_instr,
   input wire logic [15:0] o_stack_pointer,
   input wire logic [7:0] o_flags,
   input wire logic [1:0] o_length,
   input wire logic o_busy,
   input wire logic o_done
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Taken requests by opcode class; busy or done edges are refused
   wire [7:0] op = i_instr.opcode;
   wire tk = i_start && !o_busy && !o_done;
   wire t_rot = tk && op[7:1] inside {7'h48, 7'h08, 7'h70, 7'h60};
   wire t_psh = tk && op[7:1] == 7'h38;
   wire t_usr = tk && op[7:1] == 7'h41;
   wire t_ret = tk && op == OP_SUBROUTINE_RETURN;
   wire t_clc = tk && op == OP_CLEAR_CARRY;
   // Instruction end after a fixed run of quiet cycles
   sequence s_end4; !o_done [*4] ##1 o_done; endsequence
   sequence s_end8; !o_done [*8] ##1 o_done; endsequence
   sequence s_end10; !o_done [*8] ##1 !o_done [*2] ##1 o_done; endsequence
   property p_rot_time; t_rot |=> s_end4; endproperty
   a_rot_time: assert property (p_rot_time)
      else $error("rotate end time wrong");
   property p_st_time; (t_psh || t_usr) |=> s_end8; endproperty
   a_st_time: assert property (p_st_time)
      else $error("store end time wrong");
   property p_ret_time; t_ret |=> s_end10; endproperty
   a_ret_time: assert property (p_ret_time)
      else $error("return end time wrong");
   property p_clc;
      t_clc |-> ##5 o_done && !o_flags[7] && o_length == LEN_ONE
         && o_flags[6:0] == $past(o_flags[6:0], 5);
   endproperty
   a_clc: assert property (p_clc)
      else $error("carry clear wrong");
   property p_psh_sp;
      t_psh |-> ##8 o_stack_pointer == $past(o_stack_pointer, 8) - 16'h0001;
   endproperty
   a_psh_sp: assert property (p_psh_sp)
      else $error("push pointer step wrong");
   property p_st_flags; (t_psh || t_usr) |=> $stable(o_flags) [*8]; endproperty
   a_st_flags: assert property (p_st_flags)
      else $error("store touched flags");
   property p_ret_sp;
      t_ret |-> ##10 o_stack_pointer == $past(o_stack_pointer, 10) + 16'h0002;
   endproperty
   a_ret_sp: assert property (p_ret_sp)
      else $error("return pointer step wrong");
   property p_rot_dh;
      t_rot |-> ##4 o_flags[3:2] == $past(o_flags[3:2], 4)
         && o_length == LEN_TWO;
   endproperty
   a_rot_dh: assert property (p_rot_dh)
      else $error("rotate kept flags wrong");
endmodule : sarx_exec_props

// ==== verif/sarx_exec_tb_top.sv ====
/*
 Bench for sarx_exec: models register file and stack memory, notes the
 expected end state of each instruction and compares it one cycle after
 done, once a write issued with done has landed.
 Assumes sarx_pkg and the sarx_exec_props checker.
*/
`timescale 1ns/1ps
module sarx_exec_tb_top;
   import sarx_pkg::*;
   typedef struct packed {
      logic [7:0] f;
      logic [15:0] sp, pc;
      logic [1:0] len;
      logic m;
      logic [15:0] a;
      logic [7:0] d;
   } sarx_exp_type;
   logic i_clk = 1'b0, i_reset_n = 1'b0, i_start = 1'b0;
   sarx_instr_type i_instr = '0;
   logic [7:0] i_rf_rdata = 8'h00, i_mem_rdata = 8'h00;
   sarx_rf_type o_rf;
   sarx_mem_type o_mem;
   logic [15:0] o_stack_pointer, o_program_counter;
   logic [7:0] o_flags;
   logic [1:0] o_length;
   logic o_busy, o_done, o_illegal;
   logic [7:0] rf [256];
   logic [7:0] mem [65536];
   logic [7:0] ops [14] = '{OP_PUSH_R, OP_PUSH_IR, OP_USER_STACK_STORE_DOWN,
      OP_USER_STACK_STORE_UP, OP_CLEAR_CARRY, OP_SUBROUTINE_RETURN,
      OP_ROTATE_LEFT_R, OP_ROTATE_LEFT_IR, OP_RLC_R, OP_RLC_IR,
      OP_ROTATE_RIGHT_R, OP_ROTATE_RIGHT_IR, OP_RRC_R, OP_RRC_IR};
   sarx_exp_type q [$];
   sarx_exp_type e;
   int err_count = 0, checks = 0, seed = 18147;
   logic [7:0] mf = 8'h00;
   logic [15:0] msp = 16'h0000, mpc = 16'h0000;

   sarx_exec sarx_exec_i (.i_clk, .i_reset_n, .i_start, .i_instr,
      .i_rf_rdata, .i_mem_rdata, .o_rf, .o_mem, .o_stack_pointer,
      .o_program_counter, .o_flags, .o_length, .o_busy, .o_done,
      .o_illegal);

   initial forever #2.5 i_clk = ~i_clk;

   // Writes land on the edge; read data shows at the falling edge
   always @(posedge i_clk) begin
      if (o_rf.we === 1'b1) rf[o_rf.addr] <= o_rf.wdata;
      if (o_mem.we === 1'b1) mem[o_mem.addr] <= o_mem.wdata;
   end
   always @(negedge i_clk) begin
      i_rf_rdata <= rf[o_rf.addr];
      i_mem_rdata <= mem[o_mem.addr];
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // Note the expected end state, then issue one instruction
   task automatic run(input logic [7:0] op, input logic [7:0] d, s);
      sarx_exp_type t;
      logic [7:0] a, x, r;
      logic b, cn;
      int n;
      // indirect forms use the named register's content
      a = op[0] ? rf[d] : d;
      x = rf[a];
      t = '{mf, msp, mpc, LEN_TWO, 1'b0, {8'h00, a}, x};
      case (op)
         OP_CLEAR_CARRY: begin
            t.f[FLAG_C] = 1'b0;
            t.len = LEN_ONE;
         end
         // high byte at the pointer, low byte after it
         OP_SUBROUTINE_RETURN: begin
            t.pc = {mem[msp], mem[msp + 16'h0001]};
            t.sp = msp + 16'h0002;
            t.len = LEN_ONE;
            t.m = 1'b1;
            t.a = msp;
            t.d = mem[msp];
         end
         // pointer drops with wrap, then the byte is stored
         OP_PUSH_R, OP_PUSH_IR: begin
            t.sp = msp - 16'h0001;
            t.m = 1'b1;
            t.a = t.sp;
         end
         // stepped pointer addresses the stored source
         OP_USER_STACK_STORE_DOWN, OP_USER_STACK_STORE_UP: begin
            a = op[0] ? rf[d] + 8'h01 : rf[d] - 8'h01;
            t.len = LEN_THREE;
            t.a = {8'h00, a};
            t.d = rf[s];
         end
         // rotates: fill bit, carry, Z, S and V
         default: begin
            cn = op[6] ? x[0] : x[7];
            b = (op[7:4] inside {4'h1, 4'hc}) ? mf[FLAG_C] : cn;
            r = op[6] ? {b, x[7:1]} : {x[6:0], b};
            t.f[7:4] = {cn, r == 8'h00, r[7], r[7] ^ x[7]};
            t.d = r;
         end
      endcase
      if (op != OP_SUBROUTINE_RETURN)
         t.pc = mpc + {14'h0000, t.len};
      mf = t.f;
      msp = t.sp;
      mpc = t.pc;
      q.push_back(t);
      // Push source goes in both fields so either reading is covered
      i_instr <= {op, d, (op[7:4] == 4'h7) ? d : s};
      i_start <= 1'b1;
      @(negedge i_clk);
      i_start <= 1'b0;
      for (n = 0; n < 20 && o_done !== 1'b1; n++)
         @(negedge i_clk);
      if (n == 20) begin
         err_count++;
         wrap_up();
      end
      @(negedge i_clk);
   endtask : run

   // Oldest note against the state shown at each instruction end
   always @(negedge i_clk) begin
      if (o_done === 1'b1) begin
         e = q.pop_front();
         // Last write pulse goes out with done and lands on the next edge
         @(negedge i_clk);
         chk(16'(o_flags), 16'(e.f));
         chk(o_stack_pointer, e.sp);
         chk(o_program_counter, e.pc);
         chk(16'(o_length), 16'(e.len));
         chk(16'(e.m ? mem[e.a] : rf[e.a[7:0]]), 16'(e.d));
      end
   end

   // Fill memories, reset, then directed and random instruction runs
   initial begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'($random(seed));
      for (int i = 0; i < 256; i++)
         rf[i] = 8'($random(seed));
      repeat (20) @(negedge i_clk);
      i_reset_n <= 1'b1;
      @(negedge i_clk);
      run(OP_PUSH_R, 8'h40, 8'h40);
      run(OP_PUSH_IR, 8'h40, 8'h40);
      run(OP_SUBROUTINE_RETURN, 8'h00, 8'h00);
      // Opcode outside the slice: flagged, nothing started
      i_instr <= {8'hff, 8'h00, 8'h00};
      i_start <= 1'b1;
      @(negedge i_clk);
      i_start <= 1'b0;
      chk(16'(o_illegal), 16'h0001);
      chk(16'(o_busy), 16'h0000);
      chk(16'(o_flags), 16'(mf));
      @(negedge i_clk);
      $display("directed stack test done");
      for (int i = 0; i < 84; i++)
         run(ops[i % 14], 8'($random(seed)), 8'($random(seed)));
      $display("random instruction test done");
      wrap_up();
   end
endmodule : sarx_exec_tb_top

bind sarx_exec sarx_exec_props sarx_exec_props_i (.i_clk, .i_reset_n,
   .i_start, .i_instr, .o_stack_pointer, .o_flags, .o_length, .o_busy,
   .o_done);
